// ---- design/jtp_commit_guard.sv ----
// Purpose: guarded alternate-function select for the debug pins
// Assumes: write strobes are single core clock pulses
// Notes:   a plain write never moves the pins away from debug use

`timescale 1ns/100ps

module jtp_commit_guard (
	// core clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// software strobes
	input  wire logic        lock_wr,
	input  wire logic [31:0] lock_wdata,
	input  wire logic        commit_wr,
	input  wire logic        commit_wdata,
	input  wire logic        alt_function_select_bit_wr,
	input  wire logic        alt_function_select_bit_wdata,
	// guarded state
	output logic             alt_function_select_bit,
	output logic             unlocked
);

	logic commit_bit;
	wire  key_ok   = (lock_wdata == jtp_pkg::UNLOCK_KEY);
	wire  alt_function_select_bit_ok = alt_function_select_bit_wr && unlocked && commit_bit;

	// lock: right key opens, any other key closes
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			unlocked <= 1'b0;
		end else if (lock_wr) begin
			unlocked <= key_ok;
		end
	end

	// commit bit only writable while open
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			commit_bit <= jtp_pkg::COMMIT_RESET;
		end else if (commit_wr && unlocked) begin
			commit_bit <= commit_wdata;
		end
	end

	// select bit changes only through unlock and commit
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			alt_function_select_bit <= jtp_pkg::ALT_FUNCTION_SELECT_BIT_RESET;
		end else if (alt_function_select_bit_ok) begin
			alt_function_select_bit <= alt_function_select_bit_wdata; // see [RL14]
		end
	end

endmodule

// ---- design/jtp_pkg.sv ----
// Purpose: shared constants and types of the test access port
// Assumes: four-bit instruction chain, link clock separate from core clock
// Notes:   instruction codes and key values are local choices

// ****************************************************************
// package
// ****************************************************************
package jtp_pkg;

	// instruction chain
	localparam int         IR_WIDTH      = 4;
	localparam logic [3:0] IR_CAPTURE    = 4'h1;   // fixed 01 pattern in the lsbs
	localparam logic [3:0] INS_EXTEST    = 4'h0;
	localparam logic [3:0] INS_INTEST    = 4'h1;
	localparam logic [3:0] INS_SAMPLE    = 4'h2;
	localparam logic [3:0] INS_ABORT     = 4'h8;
	localparam logic [3:0] INS_DPACC     = 4'ha;
	localparam logic [3:0] INS_APACC     = 4'hb;
	localparam logic [3:0] INS_IDCODE    = 4'he;
	localparam logic [3:0] INS_BYPASS    = 4'hf;

	// data chains
	localparam int          ID_WIDTH     = 32;
	localparam logic [31:0] ID_VALUE     = 32'h1000_0001; // arbitrary value
	localparam int          BSC_WIDTH    = 8;

	// pin function guard
	localparam logic [31:0] UNLOCK_KEY   = 32'h5a5a_0001;
	localparam logic        ALT_FUNCTION_SELECT_BIT_RESET  = 1'b1;   // pins start in debug function
	localparam logic        COMMIT_RESET = 1'b0;

	// synchroniser depth
	localparam int          SYNC_STAGES  = 2;

	// port state machine
	typedef enum logic [3:0] {
		ST_RESET   = 4'h0,
		ST_IDLE    = 4'h1,
		ST_SEL_DR  = 4'h2,
		ST_CAP_DR  = 4'h3,
		ST_SHF_DR  = 4'h4,
		ST_EX1_DR  = 4'h5,
		ST_PAU_DR  = 4'h6,
		ST_EX2_DR  = 4'h7,
		ST_UPD_DR  = 4'h8,
		ST_SEL_IR  = 4'h9,
		ST_CAP_IR  = 4'ha,
		ST_SHF_IR  = 4'hb,
		ST_EX1_IR  = 4'hc,
		ST_PAU_IR  = 4'hd,
		ST_EX2_IR  = 4'he,
		ST_UPD_IR  = 4'hf
	} jtp_state_t;

	// data chain selected by the held instruction
	typedef enum logic [1:0] {
		SEL_BYPASS = 2'h0,
		SEL_IDCODE = 2'h1,
		SEL_BSC    = 2'h2,
		SEL_CORE   = 2'h3
	} jtp_sel_t;

endpackage

// ---- design/jtp_port.sv ----
// Purpose: test access port with instruction, identity, bypass and boundary chains
// Assumes: tester moves mode select and data input on the falling test clock
// Notes:   link logic runs on tck; guard and status run on core_clk

`timescale 1ns/100ps

// Function
// [RL1] state advances on rising test clock only
// [RL2] state machine times capture, shift, update
// [RL3] held instruction picks the data chain
// [RL4] external and internal test touch no chain
// [RL5] unknown instruction codes act as bypass
// [RL6] test reset low forces reset state
// [RL7] reset state loads identification instruction
// [RL8] stopped test clock keeps state and data
// [RL9] tester changes mode select on falling edge
// [RL10] tester changes data input on falling edge
// [RL11] five high mode selects reach reset
// [RL12] input bits go to selected chain
// [RL13] pins come up in debug function
// [RL14] leaving debug needs unlock and commit
// [RL15] clock driven whenever pull-up is off
// [RL16] instruction chain is four bits wide
// [RL17] data output changes on falling edge
// [RL18] data output idle unless shifting
// [RL19] output muxed with core debug controller
// [RL20] shift out lsb, shift in msb
module jtp_port #(
	parameter int          BSC_WIDTH = jtp_pkg::BSC_WIDTH,
	parameter logic [31:0] ID_VALUE  = jtp_pkg::ID_VALUE   // arbitrary value
) (
	// core clock domain
	input  wire logic                 core_clk,
	input  wire logic                 arst_n,
	// test port pins
	input  wire logic                 tck,
	input  wire logic                 trst_n,
	input  wire logic                 tms,
	input  wire logic                 tdi,
	output logic                      tdo,
	output logic                      tdo_oe,
	// core debug controller on the shared output
	input  wire logic                 core_dbg_tdo,
	output logic                      core_dbg_sel,
	// boundary cells
	input  wire logic [BSC_WIDTH-1:0] bsc_pins_in,
	output logic [BSC_WIDTH-1:0]      bsc_out,
	output logic                      ext_test_active,
	output logic                      int_test_active,
	// software strobes of the pin guard
	input  wire logic                 lock_wr,
	input  wire logic [31:0]          lock_wdata,
	input  wire logic                 commit_wr,
	input  wire logic                 commit_wdata,
	input  wire logic                 alt_function_select_bit_wr,
	input  wire logic                 alt_function_select_bit_wdata,
	// core-side status
	output logic                      alt_function_select_bit,
	output logic                      guard_unlocked,
	output logic                      link_active
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	jtp_pkg::jtp_state_t             state;
	logic [jtp_pkg::IR_WIDTH-1:0]    ir_shift;
	logic [jtp_pkg::IR_WIDTH-1:0]    ir_hold;
	logic [jtp_pkg::ID_WIDTH-1:0]    id_shift;
	logic                            byp_shift;
	logic [BSC_WIDTH-1:0]            bsc_shift;
	logic [BSC_WIDTH-1:0]            bsc_sync1;
	logic [BSC_WIDTH-1:0]            bsc_sync2;
	logic                            alt_function_select_bit_core;
	logic                            alt_function_select_bit_sync1;
	logic                            alt_function_select_bit_tck;
	logic                            act_sync1;
	logic                            act_sync2;
	logic                            tap_busy;

	// ****************************************************************
	// functions
	// ****************************************************************
	// instruction to chain, unknown codes fall back to bypass
	function automatic jtp_pkg::jtp_sel_t chain_of(input logic [3:0] ins);
		jtp_pkg::jtp_sel_t sel;
		sel = jtp_pkg::SEL_BYPASS;                     // see [RL5]
		if (ins == jtp_pkg::INS_IDCODE) begin
			sel = jtp_pkg::SEL_IDCODE;
		end else if (ins == jtp_pkg::INS_SAMPLE) begin
			sel = jtp_pkg::SEL_BSC;
		end else if (ins == jtp_pkg::INS_ABORT || ins == jtp_pkg::INS_DPACC ||
			     ins == jtp_pkg::INS_APACC) begin
			sel = jtp_pkg::SEL_CORE;
		end
		return sel;
	endfunction

	// ****************************************************************
	// reset and decode
	// ****************************************************************
	// port reset from the test reset pin or power-on reset
	wire tap_rst_n = trst_n & arst_n;                     // see [RL6]

	// state decode, one wire per phase
	wire in_reset  = (state == jtp_pkg::ST_RESET);
	wire cap_dr    = (state == jtp_pkg::ST_CAP_DR);      // see [RL2]
	wire shf_dr    = (state == jtp_pkg::ST_SHF_DR);
	wire upd_dr    = (state == jtp_pkg::ST_UPD_DR);
	wire cap_ir    = (state == jtp_pkg::ST_CAP_IR);
	wire shf_ir    = (state == jtp_pkg::ST_SHF_IR);
	wire upd_ir    = (state == jtp_pkg::ST_UPD_IR);

	// chain selected by the held instruction
	wire jtp_pkg::jtp_sel_t sel = chain_of(ir_hold);     // see [RL3]
	wire sel_byp   = (sel == jtp_pkg::SEL_BYPASS);
	wire sel_id    = (sel == jtp_pkg::SEL_IDCODE);
	wire sel_bsc   = (sel == jtp_pkg::SEL_BSC);
	wire sel_core  = (sel == jtp_pkg::SEL_CORE);

	// output bit from the lsb of the active chain
	wire dr_lsb    = sel_id  ? id_shift[0] :
			 sel_bsc ? bsc_shift[0] :
			 byp_shift;                           // see [RL20]
	wire own_bit   = shf_ir ? ir_shift[0] : dr_lsb;
	wire out_bit   = (shf_dr && sel_core) ? core_dbg_tdo : own_bit; // see [RL19]
	wire shifting  = (shf_ir || shf_dr) && alt_function_select_bit_tck;

	// ****************************************************************
	// state machine
	// ****************************************************************
	// all link flops below clock on tck alone, so a stopped
	// clock freezes state and chains alike
	jtp_tap_fsm u_fsm (
		.tck       (tck),                                 // see [RL1] see [RL8]
		.tap_rst_n (tap_rst_n),
		.tms       (tms),                                 // see [RL11]
		.state     (state)
	);

	// ****************************************************************
	// instruction chain
	// ****************************************************************
	// four-bit shift chain, fixed pattern captured
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			ir_shift <= jtp_pkg::IR_CAPTURE;
		end else if (cap_ir) begin
			ir_shift <= jtp_pkg::IR_CAPTURE;                 // see [RL16]
		end else if (shf_ir) begin
			ir_shift <= {tdi, ir_shift[jtp_pkg::IR_WIDTH-1:1]}; // see [RL12] see [RL20]
		end
	end

	// held instruction, identity code whenever in reset state
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			ir_hold <= jtp_pkg::INS_IDCODE;
		end else if (in_reset) begin
			ir_hold <= jtp_pkg::INS_IDCODE;                  // see [RL7]
		end else if (upd_ir) begin
			ir_hold <= ir_shift;
		end
	end

	// ****************************************************************
	// data chains
	// ****************************************************************
	// identity chain, read only
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			id_shift <= '0;
		end else if (cap_dr && sel_id) begin
			id_shift <= ID_VALUE;
		end else if (shf_dr && sel_id) begin
			id_shift <= {tdi, id_shift[jtp_pkg::ID_WIDTH-1:1]}; // see [RL12]
		end
	end

	// one-bit bypass, also the path for the test-apply codes
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			byp_shift <= 1'b0;
		end else if (cap_dr && sel_byp) begin
			byp_shift <= 1'b0;
		end else if (shf_dr && sel_byp) begin
			byp_shift <= tdi;                                // see [RL5] see [RL12]
		end
	end

	// pin levels reach the tck domain through two flops
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			bsc_sync1 <= '0;
			bsc_sync2 <= '0;
		end else begin
			bsc_sync1 <= bsc_pins_in;
			bsc_sync2 <= bsc_sync1;
		end
	end

	// boundary chain, sample and preload only
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			bsc_shift <= '0;
		end else if (cap_dr && sel_bsc) begin
			bsc_shift <= bsc_sync2;
		end else if (shf_dr && sel_bsc) begin
			bsc_shift <= {tdi, bsc_shift[BSC_WIDTH-1:1]};   // see [RL12] see [RL20]
		end
	end

	// boundary hold register; the test-apply codes only drive
	// what is already here and never load it
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			bsc_out <= '0;
		end else if (upd_dr && sel_bsc) begin
			bsc_out <= bsc_shift;
		end
	end

	// apply flags follow the held instruction
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			ext_test_active <= 1'b0;
			int_test_active <= 1'b0;
		end else begin
			ext_test_active <= (ir_hold == jtp_pkg::INS_EXTEST); // see [RL4]
			int_test_active <= (ir_hold == jtp_pkg::INS_INTEST); // see [RL4]
		end
	end

	// ****************************************************************
	// serial output
	// ****************************************************************
	// falling-edge launch gives the next part a full half period
	always_ff @(negedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo    <= shifting ? out_bit : 1'b0;           // see [RL17]
			tdo_oe <= shifting;                            // see [RL18]
		end
	end

	// mux select seen by the core controller
	always_ff @(negedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			core_dbg_sel <= 1'b0;
		end else begin
			core_dbg_sel <= sel_core;                      // see [RL19]
		end
	end

	// ****************************************************************
	// pin function guard
	// ****************************************************************
	jtp_commit_guard u_guard (
		.core_clk                (core_clk),
		.arst_n                  (arst_n),
		.lock_wr                 (lock_wr),
		.lock_wdata              (lock_wdata),
		.commit_wr               (commit_wr),
		.commit_wdata            (commit_wdata),
		.alt_function_select_bit_wr                (alt_function_select_bit_wr),
		.alt_function_select_bit_wdata             (alt_function_select_bit_wdata),
		.alt_function_select_bit (alt_function_select_bit_core),
		.unlocked                (guard_unlocked)
	);

	// core-side copy of the select bit for the pin mux
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			alt_function_select_bit <= jtp_pkg::ALT_FUNCTION_SELECT_BIT_RESET; // see [RL13]
		end else begin
			alt_function_select_bit <= alt_function_select_bit_core;
		end
	end

	// select bit into the link domain; resets to debug use so
	// the tester is never locked out right after reset
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			alt_function_select_bit_sync1 <= jtp_pkg::ALT_FUNCTION_SELECT_BIT_RESET;
			alt_function_select_bit_tck   <= jtp_pkg::ALT_FUNCTION_SELECT_BIT_RESET;
		end else begin
			alt_function_select_bit_sync1 <= alt_function_select_bit_core;
			alt_function_select_bit_tck   <= alt_function_select_bit_sync1;                    // see [RL13]
		end
	end

	// ****************************************************************
	// link status to the core
	// ****************************************************************
	// busy level leaves the link domain from a flop
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			tap_busy <= 1'b0;
		end else begin
			tap_busy <= !in_reset;
		end
	end

	// three-flop crossing; a stopped tck simply holds the level
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			act_sync1   <= 1'b0;
			act_sync2   <= 1'b0;
			link_active <= 1'b0;
		end else begin
			act_sync1   <= tap_busy;
			act_sync2   <= act_sync1;
			link_active <= act_sync2;
		end
	end

endmodule

// ---- design/jtp_tap_fsm.sv ----
// Purpose: sixteen-state port controller on the test clock
// Assumes: mode select is stable around the rising test clock edge
// Notes:   reset input is the combined test and power-on reset

`timescale 1ns/100ps

module jtp_tap_fsm (
	// link clock and reset
	input  wire logic               tck,
	input  wire logic               tap_rst_n,
	// mode select
	input  wire logic               tms,
	// present state
	output jtp_pkg::jtp_state_t     state
);

	jtp_pkg::jtp_state_t next_state;

	// ****************************************************************
	// transition table
	// ****************************************************************
	always_comb begin
		next_state = jtp_pkg::ST_RESET;
		case (state)
			jtp_pkg::ST_RESET:  next_state = tms ? jtp_pkg::ST_RESET  : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_IDLE:   next_state = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_SEL_DR: next_state = tms ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
			jtp_pkg::ST_CAP_DR: next_state = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SHF_DR;
			jtp_pkg::ST_SHF_DR: next_state = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SHF_DR;
			jtp_pkg::ST_EX1_DR: next_state = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PAU_DR;
			jtp_pkg::ST_PAU_DR: next_state = tms ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PAU_DR;
			jtp_pkg::ST_EX2_DR: next_state = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SHF_DR;
			jtp_pkg::ST_UPD_DR: next_state = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_SEL_IR: next_state = tms ? jtp_pkg::ST_RESET  : jtp_pkg::ST_CAP_IR;
			jtp_pkg::ST_CAP_IR: next_state = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SHF_IR;
			jtp_pkg::ST_SHF_IR: next_state = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SHF_IR;
			jtp_pkg::ST_EX1_IR: next_state = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PAU_IR;
			jtp_pkg::ST_PAU_IR: next_state = tms ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PAU_IR;
			jtp_pkg::ST_EX2_IR: next_state = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SHF_IR;
			jtp_pkg::ST_UPD_IR: next_state = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			default:            next_state = jtp_pkg::ST_RESET;
		endcase
	end

	// state register, held while the test clock stands still
	always_ff @(posedge tck or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			state <= jtp_pkg::ST_RESET;
		end else begin
			state <= next_state;
		end
	end

endmodule

// ---- verif/jtp_port_monitor.sv ----
// Purpose: concurrent checks on the pins of jtp_port
// Assumes: tck may stop at any level; core_clk runs freely
// Notes:   bound to every jtp_port instance

`timescale 1ns/100ps

// ****************************************************************
// checker
// ****************************************************************
module jtp_port_monitor #(
	parameter int BSC_WIDTH = jtp_pkg::BSC_WIDTH
) (
	// clocks and resets
	input wire logic                 core_clk,
	input wire logic                 arst_n,
	input wire logic                 tck,
	input wire logic                 trst_n,
	// link pins
	input wire logic                 tms,
	input wire logic                 tdo,
	input wire logic                 tdo_oe,
	// boundary and test flags
	input wire logic [BSC_WIDTH-1:0] bsc_out,
	input wire logic                 ext_test_active,
	input wire logic                 int_test_active,
	// pin guard and link status
	input wire logic                 lock_wr,
	input wire logic [31:0]          lock_wdata,
	input wire logic                 alt_function_select_bit,
	input wire logic                 guard_unlocked,
	input wire logic                 link_active
);
	// port side is reset by either reset pin
	wire  port_rst_n = trst_n & arst_n;
	logic tdo_rise;

	// tdo seen at each rise must still stand at the next fall;
	// a flop on the fall would only ever see the old bit
	always_ff @(posedge tck or negedge port_rst_n) begin
		if (!port_rst_n)
			tdo_rise <= 1'b0;
		else
			tdo_rise <= tdo;
	end

	sequence s_five_high;
		tms [*5];
	endsequence

	sequence s_locked;
		!guard_unlocked [*3];
	endsequence

	AST_TDO_FALL: assert property (@(negedge tck) disable iff (!port_rst_n)
		tdo == tdo_rise) else $error("tdo moved away from a falling edge");
	AST_TDO_IDLE: assert property (@(posedge core_clk) disable iff (!arst_n)
		!tdo_oe |-> !tdo) else $error("tdo not idle while undriven");
	AST_TRST_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
		!trst_n |-> !tdo_oe && !ext_test_active && !int_test_active)
		else $error("port active during test reset");
	AST_TRST_LINK: assert property (@(posedge core_clk) disable iff (!arst_n)
		!trst_n [*5] |-> !link_active) else $error("link still active in reset");
	// reset state at rise 5, held code at rise 6, flags at rise 7
	AST_FIVE_HIGH: assert property (@(posedge tck) disable iff (!port_rst_n)
		s_five_high |-> ##3 (!ext_test_active && !int_test_active && !tdo_oe))
		else $error("five high mode selects did not reset");
	AST_GPIO_OE: assert property (@(posedge tck) disable iff (!port_rst_n)
		!alt_function_select_bit [*4] |-> !tdo_oe) else $error("tdo driven in gpio mode");
	AST_BSC_HOLD: assert property (@(posedge tck) disable iff (!port_rst_n)
		ext_test_active [*2] |-> $stable(bsc_out)) else $error("boundary changed in ext test");
	AST_UNLOCK: assert property (@(posedge core_clk) disable iff (!arst_n)
		lock_wr |=> guard_unlocked == ($past(lock_wdata) == jtp_pkg::UNLOCK_KEY))
		else $error("lock state wrong after key write");
	AST_LOCKED_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
		s_locked |-> $stable(alt_function_select_bit)) else $error("select moved while locked");
	AST_RESET_DEBUG: assert property (@(posedge core_clk) disable iff (!arst_n)
		$rose(arst_n) |-> alt_function_select_bit && !guard_unlocked)
		else $error("pins not in debug function after reset");
endmodule

bind jtp_port jtp_port_monitor #(.BSC_WIDTH(BSC_WIDTH)) mon (.core_clk, .arst_n, .tck,
	.trst_n, .tms, .tdo, .tdo_oe, .bsc_out, .ext_test_active, .int_test_active, .lock_wr,
	.lock_wdata, .alt_function_select_bit, .guard_unlocked, .link_active);

// ---- verif/jtp_port_tb.sv ----
// Purpose: self-checking bench of jtp_port
// Assumes: tester model drives the link pins
// Notes:   core-side inputs move 1 ns after core_clk rises

`timescale 1ns/100ps

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
	$display("ERROR %0t got %h want %h", $time, (a), (b)); end end

// ****************************************************************
// bench
// ****************************************************************
module jtp_port_tb;
	logic        core_clk, arst_n, trst_n, tck, tms, tdi, tdo, tdo_oe;
	logic        core_dbg_tdo, core_dbg_sel, ext_test_active, int_test_active;
	logic [7:0]  bsc_pins_in, bsc_out;
	logic        lock_wr, commit_wr, commit_wdata, alt_function_select_bit_wr, alt_function_select_bit_wdata;
	logic [31:0] lock_wdata, r;
	logic        alt_function_select_bit, guard_unlocked, link_active, b;
	int          errors, n_compared;

	jtp_port dut (.core_clk(core_clk), .arst_n(arst_n), .tck(tck), .trst_n(trst_n),
		.tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .core_dbg_tdo(core_dbg_tdo),
		.core_dbg_sel(core_dbg_sel), .bsc_pins_in(bsc_pins_in), .bsc_out(bsc_out),
		.ext_test_active(ext_test_active), .int_test_active(int_test_active),
		.lock_wr(lock_wr), .lock_wdata(lock_wdata), .commit_wr(commit_wr),
		.commit_wdata(commit_wdata), .alt_function_select_bit_wr(alt_function_select_bit_wr), .alt_function_select_bit_wdata(alt_function_select_bit_wdata),
		.alt_function_select_bit(alt_function_select_bit),
		.guard_unlocked(guard_unlocked), .link_active(link_active));

	jtp_tester tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

	// 100 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic final_report();
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// bounded wait: 0 waits on link_active, 1 on the select bit
	task automatic wait_sig(input int w, input logic v);
		for (int i = 0; i < 60; i++) begin
			@(posedge core_clk);
			if (((w == 0) ? link_active : alt_function_select_bit) === v)
				return;
		end
		errors++;
		$display("ERROR %0t wait ran out", $time);
		final_report();
	endtask

	// one guard write: 0 lock, 1 commit, 2 select
	task automatic gw(input int k, input logic [31:0] d);
		@(posedge core_clk);
		#1;
		lock_wdata = d;
		commit_wdata = d[0];
		alt_function_select_bit_wdata = d[0];
		lock_wr = (k == 0);
		commit_wr = (k == 1);
		alt_function_select_bit_wr = (k == 2);
		@(posedge core_clk);
		#1;
		{lock_wr, commit_wr, alt_function_select_bit_wr} = 3'h0;
	endtask

	// instruction load; capture pattern comes back on every load
	task automatic ir(input logic [3:0] c);
		tst.scan(1'b1, 4, {28'h0, c}, -1, r);
		`CHK(r[3:0], jtp_pkg::IR_CAPTURE);
	endtask

	task automatic t_idcode();
		tst.seen_oe = 1'b0;
		tst.scan(1'b0, 32, 32'h0, 15, r);
		`CHK(r, jtp_pkg::ID_VALUE);
		`CHK(tst.seen_oe, 1'b1);
	endtask

	// unimplemented and test codes all give a one-bit path
	task automatic t_bypass();
		logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hc, 4'hf};
		foreach (codes[i]) begin
			ir(codes[i]);
			tst.scan(1'b0, 8, 32'h5b, -1, r);
			`CHK(r[7:0], 8'hb6);
			`CHK({ext_test_active, int_test_active}, {codes[i] == 4'h0, codes[i] == 4'h1});
		end
	endtask

	task automatic t_sample();
		@(posedge core_clk);
		#1;
		bsc_pins_in = 8'ha5;
		ir(jtp_pkg::INS_SAMPLE);
		tst.scan(1'b0, 8, 32'h3c, -1, r);
		`CHK(r[7:0], 8'ha5);
		`CHK(bsc_out, 8'h3c);
		ir(jtp_pkg::INS_EXTEST);
		tst.scan(1'b0, 8, 32'hff, -1, r);
		`CHK(bsc_out, 8'h3c);
	endtask

	task automatic t_core();
		logic [3:0] codes [3] = '{jtp_pkg::INS_ABORT, jtp_pkg::INS_DPACC, jtp_pkg::INS_APACC};
		core_dbg_tdo = 1'b1;
		foreach (codes[i]) begin
			ir(codes[i]);
			// select flop moves on the fall that ends the scan
			#1;
			`CHK(core_dbg_sel, 1'b1);
			tst.scan(1'b0, 8, 32'h0, -1, r);
			`CHK(r[7:0], 8'hff);
		end
		ir(jtp_pkg::INS_BYPASS);
		#1;
		`CHK(core_dbg_sel, 1'b0);
	endtask

	// abort a shift half way by five high mode selects, with the
	// external test flag up so that its clearing is watched
	task automatic t_five();
		ir(jtp_pkg::INS_EXTEST);
		tst.clk(1'b1, 1'b0, b);
		repeat (5) tst.clk(1'b0, 1'b0, b);
		tst.reset5();
		tst.scan(1'b0, 32, 32'h0, -1, r);
		`CHK(r, jtp_pkg::ID_VALUE);
	endtask

	task automatic t_trst();
		ir(jtp_pkg::INS_BYPASS);
		wait_sig(0, 1'b1);
		#1;
		trst_n = 1'b0;
		wait_sig(0, 1'b0);
		// hold long enough for the five-cycle link check
		repeat (3) @(posedge core_clk);
		#1;
		trst_n = 1'b1;
		tst.clk(1'b0, 1'b0, b);
		tst.scan(1'b0, 32, 32'h0, -1, r);
		`CHK(r, jtp_pkg::ID_VALUE);
	endtask

	// refused writes first, then unlock, commit and gpio use
	task automatic t_guard();
		`CHK(alt_function_select_bit, 1'b1);
		gw(2, 32'h0);
		gw(0, 32'h1234_0000);
		gw(1, 32'h1);
		gw(2, 32'h0);
		repeat (4) @(posedge core_clk);
		`CHK({guard_unlocked, alt_function_select_bit}, 2'h1);
		gw(0, jtp_pkg::UNLOCK_KEY);
		`CHK(guard_unlocked, 1'b1);
		gw(1, 32'h1);
		gw(2, 32'h0);
		wait_sig(1, 1'b0);
		tst.reset5();
		tst.seen_oe = 1'b0;
		tst.scan(1'b0, 8, 32'h0, -1, r);
		`CHK(tst.seen_oe, 1'b0);
		gw(2, 32'h1);
		wait_sig(1, 1'b1);
	endtask

	// reset both domains for 20 cycles, then run the scenarios
	initial begin
		errors = 0;
		n_compared = 0;
		arst_n = 1'b0;
		trst_n = 1'b0;
		core_dbg_tdo = 1'b0;
		bsc_pins_in = 8'h00;
		lock_wdata = 32'h0;
		{lock_wr, commit_wr, commit_wdata, alt_function_select_bit_wr, alt_function_select_bit_wdata} = 5'h0;
		repeat (20) @(posedge core_clk);
		#1;
		arst_n = 1'b1;
		trst_n = 1'b1;
		tst.clk(1'b0, 1'b0, b);
		t_idcode();
		t_bypass();
		t_sample();
		t_core();
		t_five();
		t_trst();
		t_guard();
		final_report();
	end
endmodule

// ---- verif/jtp_tester.sv ----
// Purpose: behavioural boundary-scan tester on the far side
// Assumes: test clock period 48 ns, parked low outside scans
// Notes:   tdo is taken just before each rising edge

`timescale 1ns/100ps

// ****************************************************************
// tester
// ****************************************************************
module jtp_tester (
	// pins toward the port
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo,
	input  wire logic tdo_oe
);
	logic seen_oe;

	// clock always driven, so the pull-up can stay off
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		seen_oe = 1'b0;
	end

	// one period; pins move just after the falling edge
	task automatic clk(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#24;
		q = tdo;
		seen_oe = seen_oe | tdo_oe;
		tck = 1'b1;
		#24;
		tck = 1'b0;
	endtask

	// reset by mode select alone, then park in idle
	task automatic reset5();
		logic q;
		repeat (5) clk(1'b1, ~tdi, q);
		clk(1'b0, ~tdi, q);
	endtask

	// idle to idle scan, lsb first; tdi toggles when unused
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		input int pause, output logic [31:0] dout);
		logic q;
		dout = '0;
		clk(1'b1, ~tdi, q);
		if (ir)
			clk(1'b1, ~tdi, q);
		clk(1'b0, ~tdi, q);
		clk(1'b0, ~tdi, q);
		for (int i = 0; i < n; i++) begin
			if (i == pause)
				#2000;
			clk(i == n - 1, din[i], q);
			dout[i] = q;
		end
		clk(1'b1, ~tdi, q);
		clk(1'b0, ~tdi, q);
	endtask
endmodule
